/* File: src/ipa_top.sv */
// control-port slave with direct byte registers and indirect parameter store access
// assumes the bus master drives all transfers; scl and sda arrive asynchronously
// Notes on behaviour
// - direct write: address, subaddress, data, stop
// - direct read: subaddress, repeated start, byte out
// - status bit 2 shows store busy
// - two bytes at 37h latch write address
// - two bytes at 38h store word there
// - two bytes at 36h fetch word, busy meanwhile
// - read at 38h returns fetched word, two bytes
// - slave always accessible, never locked at power-up
`timescale 1ns/1ps
module ipa_top import ipa_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = DEV_ADDR,        // seven-bit bus address
  parameter logic [7:0] MAKER_ID   = MAKER_ID_VALUE,  // arbitrary identification value
  parameter int         RAM_AW     = RAM_ADDR_BITS,   // implemented store depth log2
  parameter int         RAM_LAT    = RAM_LATENCY      // store access latency in cycles
) (
  input  wire logic       REF_CLK_IN,
  input  wire logic       NRST_IN,
  input  wire logic       CE_IN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N_OUT,
  output logic [7:0]      OUTPUT_PAD_ENABLE_OUT
);
  // subaddresses that carry a two-byte word
  function automatic logic is_word_sub(input logic [7:0] s);
    return (s == SUB_RADDR) || (s == SUB_WADDR) || (s == SUB_DATA);
  endfunction

  ipa_ram_if ram_bus ();  // link to the parameter store

  logic [1:0] pins_s;     // synchronised {scl, sda}
  logic       scl_s;      // synchronised clock line
  logic       sda_s;      // synchronised data line
  logic       scl_d;      // previous clock level
  logic       sda_d;      // previous data level

  ipa_state_e  state;      // byte-level position in the transfer
  logic [2:0]  bit_cnt;    // bit within the byte
  logic        ack_ph;     // in the ninth (acknowledge) bit
  logic        ack_drive;  // we pull the acknowledge low
  logic [7:0]  shreg;      // byte being shifted in or out
  logic [7:0]  sub;        // current subaddress
  logic [1:0]  byte_idx;   // byte within a write to sub
  logic        rd_idx;     // byte within a word read
  logic [7:0]  hi_byte;    // first byte of a word write
  logic [7:0]  pad;        // output_pad_enable
  logic        busy;       // parameter store busy
  logic [15:0] raddr;      // read address
  logic [15:0] waddr;      // write address
  logic [15:0] rd_word;    // word fetched from the store
  logic        fetch_pend; // outstanding access returns read data
  logic        out_low;    // registered pull-low of sda
  logic        req;        // request pulse to the store
  logic        req_we;     // request kind
  logic [15:0] req_addr;   // request address
  logic [15:0] req_wdata;  // request write word
  logic        skip_fall;  // swallow the clock fall that closes a start

  // the bus lines are sampled by REF_CLK_IN only, so every bus event reaches the
  // logic about three cycles late; the bus clock must stay slow enough that a
  // low phase spans at least six reference cycles, or a driven bit would move
  // while the master samples it
  // edge and condition decode on the synchronised lines
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_end  = scl_fall & ~ack_ph & (bit_cnt == 3'h7);
  wire addr_hit  = (shreg[7:1] == SLAVE_ADDR);
  wire [15:0] word_in = {hi_byte, shreg};
  wire word_done = (state == ST_WR) && is_word_sub(sub) && (byte_idx == 2'h1);

  // reads are answered from whatever sub holds; sub survives a repeated start
  // and the end of a transfer, so a bare read repeats the last register
  // read selection
  wire [7:0] status_byte = {7'h00, busy} << BUSY_BIT;
  wire [7:0] data_byte   = rd_idx ? rd_word[7:0] : rd_word[15:8];
  wire [7:0] rd_byte     = (sub == SUB_MAKER)  ? MAKER_ID :
                           (sub == SUB_STATUS) ? status_byte :
                           (sub == SUB_PAD)    ? pad :
                           (sub == SUB_DATA)   ? data_byte : 8'h00;

  // pull-low request: acknowledge we give, or a zero data bit
  // registered in out_low so the pin never glitches on decode hazards
  wire drive_now = (ack_ph & ack_drive) | ((state == ST_RD) & ~ack_ph & ~shreg[7]);

  // a store request goes out on any completed word at 36h..38h
  wire acc_raddr = byte_end & word_done & (sub == SUB_RADDR);
  wire acc_waddr = byte_end & word_done & (sub == SUB_WADDR);
  wire acc_wdata = byte_end & word_done & (sub == SUB_DATA);

  // both bus lines share one synchroniser so their relative order is kept
  ipa_sync #(
    .W (2)
  ) u_sync (
    .clk_in  (REF_CLK_IN),
    .nrst_in (NRST_IN),
    .ce_in   (CE_IN),
    .d_in    ({SCL_IN, SDA_IN}),
    .q_out   (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // the store sees plain request wires; the request flops sit in this module
  ipa_ram #(
    .AW  (RAM_AW),
    .LAT (RAM_LAT)
  ) u_ram (
    .clk_in  (REF_CLK_IN),
    .nrst_in (NRST_IN),
    .ce_in   (CE_IN),
    .bus     (ram_bus.ram)
  );
  assign ram_bus.req   = req;
  assign ram_bus.we    = req_we;
  assign ram_bus.addr  = req_addr;
  assign ram_bus.wdata = req_wdata;

  // open-drain pin: oe low while pulling the line low
  // SDA_OUT is the value driven while enabled; only a pull-low is ever made
  assign SDA_OUT               = 1'b0;
  assign SDA_OE_N_OUT          = ~out_low;
  assign OUTPUT_PAD_ENABLE_OUT = pad;

  // delayed line levels for edge detection, plus the output flop
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      out_low <= 1'b0;
    end else if (CE_IN) begin
      scl_d   <= scl_s;
      sda_d   <= sda_s;
      out_low <= drive_now;
    end
  end

  // bit_cnt counts clock falls within a byte; byte_end marks the fall of the
  // eighth bit, after which ack_ph covers the ninth. a start sets skip_fall
  // because the clock fall that closes it belongs to no bit
  // byte-level slave; no power-up lock, it answers from the first edge
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state     <= ST_IDLE;
      bit_cnt   <= 3'h0;
      ack_ph    <= 1'b0;
      ack_drive <= 1'b0;
      shreg     <= 8'h00;
      sub       <= 8'h00;
      byte_idx  <= 2'h0;
      rd_idx    <= 1'b0;
      hi_byte   <= 8'h00;
      skip_fall <= 1'b0;
    end else if (CE_IN) begin
      if (start_det) begin
        // start or repeated start: sub is kept for the read that follows
        state     <= ST_ADDR;
        bit_cnt   <= 3'h0;
        skip_fall <= 1'b1;  // the closing fall of the start is no data bit
        ack_ph    <= 1'b0;
        ack_drive <= 1'b0;
      end else if (stop_det) begin
        skip_fall <= 1'b0;
        state     <= ST_IDLE;
        ack_ph    <= 1'b0;
        ack_drive <= 1'b0;
      end else if (state != ST_IDLE) begin
        if (scl_rise && !ack_ph && state != ST_RD) begin
          shreg <= {shreg[6:0], sda_s};  // sample master bits on the rising clock
        end else if (scl_rise && ack_ph && !ack_drive && sda_s) begin
          state <= ST_IDLE;  // master said no more bytes
        end
        if (byte_end) begin
          bit_cnt <= 3'h0;
          ack_ph  <= 1'b1;
          case (state)
            ST_ADDR: begin
              ack_drive <= addr_hit;
              rd_idx    <= 1'b0;
              if (!addr_hit) begin
                state  <= ST_IDLE;  // another slave's transfer
                ack_ph <= 1'b0;
              end else if (shreg[0]) begin
                state <= ST_RD;
              end else begin
                state <= ST_SUB;
              end
            end
            ST_SUB: begin
              ack_drive <= 1'b1;
              sub       <= shreg;
              byte_idx  <= 2'h0;
              state     <= ST_WR;
            end
            ST_WR: begin
              ack_drive <= 1'b1;
              hi_byte   <= shreg;  // first byte is the upper one
              if (byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 2'h1;  // extra bytes beyond a word are ignored
              end
            end
            ST_RD: begin
              ack_drive <= 1'b0;  // master owns the ninth bit
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end else if (scl_fall && ack_ph) begin
          ack_ph    <= 1'b0;
          ack_drive <= 1'b0;
          if (state == ST_RD) begin
            shreg  <= rd_byte;  // next byte to send
            rd_idx <= ~rd_idx;
          end
        end else if (scl_fall && skip_fall) begin
          skip_fall <= 1'b0;  // first fall after a start: count nothing
        end else if (scl_fall) begin
          bit_cnt <= bit_cnt + 3'h1;
          if (state == ST_RD) begin
            shreg <= {shreg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // every byte of a write to f2h lands here; the last one wins
  // direct byte register writes
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pad <= PAD_RESET;
    end else if (CE_IN && byte_end && state == ST_WR && sub == SUB_PAD) begin
      pad <= shreg;
    end
  end

  // only one store access can be in flight; the store drops a request while
  // busy, so a master that skips the busy poll loses the later word; the
  // write-address load also makes a dummy read so that busy behaves the same
  // for all three word subaddresses
  // indirect access: latch addresses, issue store requests
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      raddr      <= 16'h0000;
      waddr      <= 16'h0000;
      req        <= 1'b0;
      req_we     <= 1'b0;
      req_addr   <= 16'h0000;
      req_wdata  <= 16'h0000;
      fetch_pend <= 1'b0;
    end else if (CE_IN) begin
      req <= 1'b0;
      if (acc_raddr) begin
        raddr      <= word_in;
        req        <= 1'b1;
        req_we     <= 1'b0;
        req_addr   <= word_in;
        fetch_pend <= 1'b1;
      end else if (acc_waddr) begin
        waddr      <= word_in;
        req        <= 1'b1;     // dummy access so busy spans the load
        req_we     <= 1'b0;
        req_addr   <= word_in;
        fetch_pend <= 1'b0;
      end else if (acc_wdata) begin
        req        <= 1'b1;
        req_we     <= 1'b1;
        req_addr   <= waddr;
        req_wdata  <= word_in;
        fetch_pend <= 1'b0;
      end
    end
  end

  // busy rises the cycle after a word is accepted and falls the cycle after
  // the store pulses done, RAM_LAT plus two cycles later in all
  // busy flag and fetched word; a new accept beats a completion
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      busy    <= 1'b0;
      rd_word <= 16'h0000;
    end else if (CE_IN) begin
      if (acc_raddr || acc_waddr || acc_wdata) begin
        busy <= 1'b1;
      end else if (ram_bus.done) begin
        busy <= 1'b0;
      end
      if (ram_bus.done && fetch_pend) begin
        rd_word <= ram_bus.rdata;
      end
    end
  end
endmodule // ipa_top

/* File: src/ipa_pkg.sv */
// constants shared by the control-port slave and its parameter store
// assumes nothing beyond a synthesis tool that reads packages
package ipa_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h43;  // bus address, 8'h86 write / 8'h87 read
  localparam logic [7:0] SUB_MAKER       = 8'h00;  // maker_id
  localparam logic [7:0] SUB_STATUS      = 8'h35;  // param_ram_status
  localparam logic [7:0] SUB_RADDR       = 8'h36;  // param_ram_read_addr
  localparam logic [7:0] SUB_WADDR       = 8'h37;  // param_ram_write_addr
  localparam logic [7:0] SUB_DATA        = 8'h38;  // param_ram_data
  localparam logic [7:0] SUB_PAD         = 8'hf2;  // output_pad_enable
  localparam int         BUSY_BIT        = 2;      // busy flag position in status
  localparam logic [7:0] PAD_RESET       = 8'h00;  // output_pad_enable after reset
  localparam logic [7:0] MAKER_ID_VALUE  = 8'h5a;  // arbitrary identification value
  localparam int         RAM_LATENCY     = 4;      // cycles for one parameter store access
  localparam int         RAM_ADDR_BITS   = 8;      // implemented parameter store depth log2
  // one-hot states of the byte-level slave
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_SUB  = 5'b00100,
    ST_WR   = 5'b01000,
    ST_RD   = 5'b10000
  } ipa_state_e;
endpackage

/* File: src/ipa_ram_if.sv */
// request and answer wires between the slave and the parameter store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ipa_ram_if;
  logic        req;    // one-cycle access request
  logic        we;     // request writes when high
  logic [15:0] addr;   // word address
  logic [15:0] wdata;  // word to store
  logic [15:0] rdata;  // word fetched, valid with done
  logic        done;   // one-cycle completion pulse
  modport host (output req, output we, output addr, output wdata, input rdata, input done);
  modport ram  (input req, input we, input addr, input wdata, output rdata, output done);
endinterface

/* File: src/ipa_sync.sv */
// two-stage synchroniser for inputs from outside the clock domain
// assumes ce freezes both stages like all other state
`timescale 1ns/1ps
module ipa_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;  // first stage, read only by the second

  // idle bus level is high, so both stages reset high
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta  <= '1;
      q_out <= '1;
    end else if (ce_in) begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // ipa_sync

/* File: src/ipa_ram.sv */
// parameter store: word array with a fixed access latency
// assumes one request at a time; a request while busy is dropped
`timescale 1ns/1ps
module ipa_ram import ipa_pkg::*; #(
  parameter int AW  = RAM_ADDR_BITS,
  parameter int LAT = RAM_LATENCY
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  ipa_ram_if.ram    bus
);
  logic [15:0]   mem [0:(1<<AW)-1];  // parameter words, no reset
  logic [7:0]    cnt;                // latency countdown
  logic          act;                // access in flight
  logic          we_q;               // latched request kind
  logic [AW-1:0] a_q;                // latched address
  logic [15:0]   d_q;                // latched write word

  // control: latch request, count latency, pulse done
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      act      <= 1'b0;
      cnt      <= 8'h00;
      we_q     <= 1'b0;
      a_q      <= '0;
      d_q      <= 16'h0000;
      bus.done <= 1'b0;
    end else if (ce_in) begin
      bus.done <= 1'b0;
      if (!act && bus.req) begin
        act  <= 1'b1;
        cnt  <= 8'(LAT - 1);
        we_q <= bus.we;
        a_q  <= bus.addr[AW-1:0];  // upper address bits fold onto the implemented depth
        d_q  <= bus.wdata;
      end else if (act) begin
        if (cnt == 8'h00) begin
          act      <= 1'b0;
          bus.done <= 1'b1;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end

  // array port: write and read happen at the end of the latency
  always_ff @(posedge clk_in) begin
    if (ce_in && act && cnt == 8'h00) begin
      if (we_q) begin
        mem[a_q] <= d_q;
      end
      bus.rdata <= mem[a_q];
    end
  end
endmodule // ipa_ram

/* File: tb/ipa_checker.sv */
// pin assertions for the control-port slave
// assumes bind onto ipa_top and a bus clock far slower than REF_CLK_IN
`timescale 1ns/1ps
module ipa_checker import ipa_pkg::*; (
  input wire logic       REF_CLK_IN,
  input wire logic       NRST_IN,
  input wire logic       CE_IN,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE_N_OUT,
  input wire logic [7:0] OUTPUT_PAD_ENABLE_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  // a pulled-low bit stands at least one bus low phase
  sequence s_pull;
    !SDA_OE_N_OUT [*8];
  endsequence
  // reset leaves the wire free and the pad register cleared
  oe_reset_a: assert property (!NRST_IN |-> SDA_OE_N_OUT) else $error("sda driven in reset");
  pad_reset_a: assert property (!NRST_IN |-> OUTPUT_PAD_ENABLE_OUT == PAD_RESET) else $error("pad not cleared");
  sda_low_a: assert property (disable iff (!NRST_IN) SDA_OUT == 1'b0) else $error("sda value not low");
  // the register moves only in a clock low phase, then the byte is acknowledged
  pad_when_a: assert property (disable iff (!NRST_IN) $changed(OUTPUT_PAD_ENABLE_OUT) |-> !SCL_IN)
    else $error("pad changed with scl high");
  pad_ack_a: assert property (disable iff (!NRST_IN) $changed(OUTPUT_PAD_ENABLE_OUT) |-> ##[0:6] !SDA_OE_N_OUT)
    else $error("pad write not acknowledged");
  // a driven bit must not move while the master samples it
  drive_held_a: assert property (disable iff (!NRST_IN) SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_N_OUT))
    else $error("sda moved with scl high");
  pull_len_a: assert property (disable iff (!NRST_IN) $fell(SDA_OE_N_OUT) |-> s_pull)
    else $error("pull-low too short");
  ce_freeze_a: assert property (disable iff (!NRST_IN) !CE_IN |=>
    $stable(OUTPUT_PAD_ENABLE_OUT) && $stable(SDA_OE_N_OUT)) else $error("outputs moved while frozen");
endmodule // ipa_checker
bind ipa_top ipa_checker u_chk (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT), .OUTPUT_PAD_ENABLE_OUT(OUTPUT_PAD_ENABLE_OUT));

/* File: tb/ipa_master.sv */
// bus master model standing in for the host controller
// assumes a pull-up on the wire: sda_out high means released
`timescale 1ns/1ps
module ipa_master import ipa_pkg::*; (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  localparam realtime Q = 31.25; // quarter of the 125 ns bus clock
  logic ack_bad;                 // sticky: an expected acknowledge was missing
  // clock stands still high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    ack_bad = 1'b0;
  end
  // one bit: data set in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    #Q scl_out <= 1'b1;
    #Q r = sda_in;
    #Q scl_out <= 1'b0;
    #Q;
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_out <= 1'b1;
    #Q scl_out <= 1'b1;
    #Q sda_out <= 1'b0;
    #Q scl_out <= 1'b0;
    #Q;
  endtask
  // stop, then the clock stays high
  task automatic stop();
    sda_out <= 1'b0;
    #Q scl_out <= 1'b1;
    #Q sda_out <= 1'b1;
    #Q;
  endtask
  // byte out, msb first; a high ninth bit is a refusal
  task automatic put(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], a);
    end
    bit_io(1'b1, a);
    ack_bad = ack_bad | a;
  endtask
  // byte in; the last byte of a read gets no acknowledge so the slave lets go
  task automatic get(input logic last, output logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, a);
  endtask
  // whole transfer: address, subaddress, then n bytes written or read back
  task automatic xfer(input logic [7:0] s, input logic rd, input logic [15:0] d, input int n, output logic [15:0] q);
    q = 16'h0000;
    start();
    put({DEV_ADDR, 1'b0});
    put(s);
    if (rd) begin
      start();
      put({DEV_ADDR, 1'b1});
      for (int i = n; i > 0; i--) begin
        get(i == 1, q[8*i-1 -: 8]);
      end
    end else begin
      for (int i = n; i > 0; i--) begin
        put(d[8*i-1 -: 8]);
      end
    end
    stop();
  endtask
  // wait for the store to go idle, bounded to eight reads
  task automatic poll(output logic [7:0] st);
    logic [15:0] q;
    for (int i = 0; i < 8; i++) begin
      xfer(SUB_STATUS, 1'b1, 16'h0000, 1, q);
      st = q[7:0];
      if (!q[BUSY_BIT]) break;
    end
  endtask
endmodule // ipa_master

/* File: tb/tb_top.sv */
// self-checking bench for the control-port slave
// assumes the master model and the bound checker beside it
`timescale 1ns/1ps
module tb_top import ipa_pkg::*;;
  logic        clk;             // 100 MHz reference
  logic        rst_n;           // active-low reset
  logic        ce;              // clock enable
  logic        scl;             // bus clock from the master
  logic        m_sda;           // master data, open drain
  logic        sda_out;         // slave data value
  logic        sda_oe_n;        // slave drives when low
  logic [7:0]  pad;             // pad enable register
  logic [15:0] q;               // read result
  logic [7:0]  st;              // status byte
  int          n_mismatch = 0;  // mismatches seen
  int          checks = 0;      // comparisons made
  wire         sda_w = m_sda & (sda_oe_n | sda_out); // pulled-up wire
  ipa_top u_dut (.REF_CLK_IN(clk), .NRST_IN(rst_n), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE_N_OUT(sda_oe_n), .OUTPUT_PAD_ENABLE_OUT(pad));
  ipa_master u_m (.sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  // one compare for every kind of result, widened to a word
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // direct registers straight after reset, refused address, frozen clock
  task automatic t_direct();
    chk("pad reset", {8'h00, PAD_RESET}, {8'h00, pad});
    chk("oe reset", 16'h0001, {15'h0, sda_oe_n});
    u_m.xfer(SUB_MAKER, 1'b1, 16'h0000, 1, q);
    chk("maker", {8'h00, MAKER_ID_VALUE}, q);
    u_m.xfer(SUB_MAKER, 1'b0, 16'h0077, 1, q);
    u_m.xfer(SUB_PAD, 1'b0, 16'h00a5, 1, q);
    chk("pad out", 16'h00a5, {8'h00, pad});
    u_m.xfer(SUB_PAD, 1'b1, 16'h0000, 1, q);
    chk("pad read", 16'h00a5, q);
    u_m.xfer(SUB_MAKER, 1'b1, 16'h0000, 1, q);
    chk("maker kept", {8'h00, MAKER_ID_VALUE}, q);
    u_m.xfer(8'h10, 1'b1, 16'h0000, 1, q);
    chk("unmapped", 16'h0000, q);
    chk("acks", 16'h0000, {15'h0, u_m.ack_bad});
    u_m.start();
    u_m.put(8'h88);
    u_m.stop();
    chk("wrong addr", 16'h0001, {15'h0, u_m.ack_bad});
    u_m.ack_bad = 1'b0;
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    chk("pad frozen", 16'h00a5, {8'h00, pad});
  endtask
  // indirect store write: address word, wait, data word, wait
  task automatic st_word(input logic [15:0] a, input logic [15:0] d);
    u_m.poll(st);
    u_m.xfer(SUB_WADDR, 1'b0, a, 2, q);
    u_m.poll(st);
    u_m.xfer(SUB_DATA, 1'b0, d, 2, q);
    u_m.poll(st);
    chk("status idle", 16'h0000, {8'h00, st});
  endtask
  // indirect store read: address word, wait, two bytes back
  task automatic ld_word(input logic [15:0] a, input logic [15:0] d);
    u_m.xfer(SUB_RADDR, 1'b0, a, 2, q);
    u_m.poll(st);
    chk("status idle", 16'h0000, {8'h00, st});
    u_m.xfer(SUB_DATA, 1'b1, 16'h0000, 2, q);
    chk("store word", d, q);
  endtask
  // two locations, read back in the order they were written
  task automatic t_indirect();
    st_word(16'h0012, 16'hbeef);
    st_word(16'h0034, 16'h1234);
    ld_word(16'h0012, 16'hbeef);
    ld_word(16'h0034, 16'h1234);
    chk("acks", 16'h0000, {15'h0, u_m.ack_bad});
  endtask
  // reset in mid-run clears the pad register; the port answers at once
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pad cleared", {8'h00, PAD_RESET}, {8'h00, pad});
    rst_n <= 1'b1;
    u_m.xfer(SUB_PAD, 1'b1, 16'h0000, 1, q);
    chk("pad after reset", {8'h00, PAD_RESET}, q);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run is near 11k cycles; give it 40k
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    ce    = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_direct();
    t_indirect();
    t_reset();
    complete_run();
  end
endmodule // tb_top
